/* File: rtl/hssp_strap_status.sv */
// strap sampling and status output muxing for the gang and auto-charge pins
`timescale 1ns/1ps
`default_nettype none

module hssp_strap_status #(
    parameter int PORTS = hssp_pkg::PORT_N
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic GANG_PIN_IN,
    output logic GANG_PIN_OUT,
    output logic GANG_PIN_OE_N,
    input wire logic AUTO_PIN_IN,
    output logic AUTO_PIN_OUT,
    output logic AUTO_PIN_OE_N,
    input wire logic TWOWIRE_SLAVE_MODE_SELECT_N,
    input wire logic [hssp_pkg::ADDR_W-1:0] SLAVE_ADDR_OTHER,
    input wire logic STATUS_PIN_OUTPUT_ENABLE,
    input wire logic UPSTREAM_HIGHSPEED_LINK_STATUS,
    input wire logic UPSTREAM_HIGHSPEED_SUSPEND_STATUS,
    input wire logic [PORTS-1:0] CHARGING_DOWNSTREAM_PORT_REQUEST,
    output logic [hssp_pkg::ADDR_W-1:0] SLAVE_ADDR,
    output logic GANGED_POWER,
    output logic AUTO_CHARGE_DISABLE_BIT,
    output logic AUTO_CHARGE_MODE,
    output logic [PORTS-1:0] CHARGING_DOWNSTREAM_PORT_MODE,
    output logic STRAPS_VALID
);

    // ==========================================
    // strap capture
    hssp_pkg::hssp_state_t state_r, state_nxt;
    logic gang_r, gang_nxt;
    logic auto_dis_r, auto_dis_nxt;
    logic drive_r, drive_nxt;
    logic link_r, link_nxt;
    logic susp_r, susp_nxt;
    logic [hssp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [PORTS-1:0] chg_port_r, chg_port_nxt;

    always_comb
    begin
        state_nxt = state_r;
        gang_nxt = gang_r;
        auto_dis_nxt = auto_dis_r;
        unique case (state_r)
            hssp_pkg::ST_RESET:
            begin
                state_nxt = hssp_pkg::ST_SAMPLE;
            end
            hssp_pkg::ST_SAMPLE:
            begin
                // gang strap taken at reset release
                gang_nxt = GANG_PIN_IN;
                // auto-charge strap taken at reset release
                // level lands in the disable bit
                auto_dis_nxt = AUTO_PIN_IN;
                state_nxt = hssp_pkg::ST_RUN;
            end
            hssp_pkg::ST_RUN:
            begin
                state_nxt = hssp_pkg::ST_RUN;
            end
            default:
            begin
                state_nxt = hssp_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            state_r <= hssp_pkg::ST_RESET;
            gang_r <= hssp_pkg::GANG_RST;
            auto_dis_r <= hssp_pkg::AUTO_DIS_RST;
        end
        else
        begin
            state_r <= state_nxt;
            gang_r <= gang_nxt;
            auto_dis_r <= auto_dis_nxt;
        end
    end

    // ==========================================
    // status outputs and derived modes
    logic auto_mode;
    assign auto_mode = (state_r == hssp_pkg::ST_RUN) && (auto_dis_r == hssp_pkg::AUTO_CHARGE_ON);

    always_comb
    begin
        // drive only after sampling and while enabled
        drive_nxt = (state_r == hssp_pkg::ST_RUN) && STATUS_PIN_OUTPUT_ENABLE;
        // gang pin follows high-speed link status
        link_nxt = UPSTREAM_HIGHSPEED_LINK_STATUS;
        susp_nxt = UPSTREAM_HIGHSPEED_SUSPEND_STATUS;
        addr_nxt = SLAVE_ADDR_OTHER;
        // gang strap supplies address bit 2 in slave mode
        if (!TWOWIRE_SLAVE_MODE_SELECT_N)
        begin
            addr_nxt[hssp_pkg::ADDR_BIT_GANG] = gang_r;
        end
        chg_port_nxt = CHARGING_DOWNSTREAM_PORT_REQUEST;
        // port 1 never gets charging-downstream-port mode in auto mode
        if (auto_mode)
        begin
            chg_port_nxt[hssp_pkg::AUTO_BLOCKED_PORT-1] = 1'h0;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            drive_r <= 1'h0;
            link_r <= 1'h0;
            susp_r <= 1'h0;
            addr_r <= '0;
            chg_port_r <= '0;
        end
        else
        begin
            drive_r <= drive_nxt;
            link_r <= link_nxt;
            susp_r <= susp_nxt;
            addr_r <= addr_nxt;
            chg_port_r <= chg_port_nxt;
        end
    end

    assign GANG_PIN_OUT = link_r;
    assign AUTO_PIN_OUT = susp_r;
    assign GANG_PIN_OE_N = !drive_r;
    assign AUTO_PIN_OE_N = !drive_r;
    assign SLAVE_ADDR = addr_r;
    assign GANGED_POWER = (gang_r != hssp_pkg::GANG_INDIVIDUAL);
    assign AUTO_CHARGE_DISABLE_BIT = auto_dis_r;
    assign AUTO_CHARGE_MODE = auto_mode;
    assign CHARGING_DOWNSTREAM_PORT_MODE = chg_port_r;
    assign STRAPS_VALID = (state_r == hssp_pkg::ST_RUN);

    // ==========================================
    // checks
    // address bit source
    a_addr_bit_gang: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (!TWOWIRE_SLAVE_MODE_SELECT_N && state_r == hssp_pkg::ST_RUN)
        |=> SLAVE_ADDR[hssp_pkg::ADDR_BIT_GANG] == $past(gang_r))
        else $error("address bit 2 not from gang strap");

    a_addr_other_bits: assert property (@(posedge CORE_CLK) disable iff (SRST)
        TWOWIRE_SLAVE_MODE_SELECT_N |=> SLAVE_ADDR == $past(SLAVE_ADDR_OTHER))
        else $error("slave address not from other bits");

    a_gang_link_out: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (!GANG_PIN_OE_N) |-> GANG_PIN_OUT == $past(UPSTREAM_HIGHSPEED_LINK_STATUS))
        else $error("gang pin not showing link status");

    a_auto_strap_take: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (state_r == hssp_pkg::ST_SAMPLE)
        |=> AUTO_CHARGE_MODE == ($past(AUTO_PIN_IN) == hssp_pkg::AUTO_CHARGE_ON))
        else $error("auto mode not set from strap");

    a_port1_charge_off: assert property (@(posedge CORE_CLK) disable iff (SRST)
        auto_mode |=> !CHARGING_DOWNSTREAM_PORT_MODE[hssp_pkg::AUTO_BLOCKED_PORT-1])
        else $error("port 1 charging mode in auto mode");

    a_port_req_pass: assert property (@(posedge CORE_CLK) disable iff (SRST)
        !auto_mode
        |=> CHARGING_DOWNSTREAM_PORT_MODE == $past(CHARGING_DOWNSTREAM_PORT_REQUEST))
        else $error("charging mode request not passed");

    a_disable_bit_load: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (state_r == hssp_pkg::ST_SAMPLE) |=> AUTO_CHARGE_DISABLE_BIT == $past(AUTO_PIN_IN)
        ##1 AUTO_CHARGE_DISABLE_BIT == $past(AUTO_CHARGE_DISABLE_BIT))
        else $error("disable bit not loaded from strap");

    a_auto_susp_out: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (!AUTO_PIN_OE_N) |-> AUTO_PIN_OUT == $past(UPSTREAM_HIGHSPEED_SUSPEND_STATUS))
        else $error("auto pin not showing suspend status");

    a_gang_strap_take: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (state_r == hssp_pkg::ST_SAMPLE) |=> GANGED_POWER == $past(GANG_PIN_IN))
        else $error("gang strap not captured");

    a_strap_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
        STRAPS_VALID |=> $stable(GANGED_POWER) && $stable(AUTO_CHARGE_DISABLE_BIT))
        else $error("strap value changed after sampling");

    a_pins_input_early: assert property (@(posedge CORE_CLK)
        $fell(SRST) |-> GANG_PIN_OE_N && AUTO_PIN_OE_N ##1 GANG_PIN_OE_N
        ##1 GANG_PIN_OE_N)
        else $error("pin driven before straps sampled");

    a_drive_needs_en: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (!GANG_PIN_OE_N) |-> $past(STATUS_PIN_OUTPUT_ENABLE) && $past(STRAPS_VALID))
        else $error("pin driven without enable");

    a_drive_when_en: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (STRAPS_VALID && STATUS_PIN_OUTPUT_ENABLE) |=> !GANG_PIN_OE_N && !AUTO_PIN_OE_N)
        else $error("pin not driven while enabled");

    a_straps_valid_time: assert property (@(posedge CORE_CLK) disable iff (SRST)
        $fell(SRST) |-> !STRAPS_VALID ##1 !STRAPS_VALID ##1 STRAPS_VALID)
        else $error("straps not valid on time");

endmodule

`default_nettype wire

/* File: rtl/hssp_pkg.sv */
// constants for the hub strap and status pin block
package hssp_pkg;
    // strap levels
    localparam logic GANG_INDIVIDUAL = 1'h0;
    localparam logic AUTO_CHARGE_ON = 1'h0;
    // reset values of sampled straps (pin pull defaults)
    localparam logic GANG_RST = 1'h0;
    localparam logic AUTO_DIS_RST = 1'h1;
    // slave address bit fed by the gang strap
    localparam int ADDR_BIT_GANG = 2;
    localparam int ADDR_W = 7;
    // downstream port index that loses charging-downstream-port mode in auto mode
    localparam int AUTO_BLOCKED_PORT = 1;
    localparam int PORT_N = 4;
    // state encoding, gray along reset -> sample -> run
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_RUN = 2'h3
    } hssp_state_t;
endpackage

/* File: verif/hssp_board_model.sv */
// board strap resistors and status pin wires
`timescale 1ns/1ps
`default_nettype none
module hssp_board_model (
    input wire logic gang_strap,
    input wire logic auto_strap,
    input wire logic gang_out,
    input wire logic gang_oe_n,
    input wire logic auto_out,
    input wire logic auto_oe_n,
    output logic gang_wire,
    output logic auto_wire
);
    // strap resistor level while the pin is released
    assign gang_wire = gang_oe_n ? gang_strap : gang_out;
    assign auto_wire = auto_oe_n ? auto_strap : auto_out;
endmodule
`default_nettype wire

/* File: verif/test_hub_strap_and_status_pins.sv */
// self-checking bench for strap sampling and status pins
`timescale 1ns/1ps
`default_nettype none
module test_hub_strap_and_status_pins;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic gs = 1'h0, as = 1'h1, sel_n = 1'h1, en = 1'h0, lnk = 1'h0, sus = 1'h0;
    logic [6:0] oth = 7'h00;
    logic [3:0] req = 4'h0;
    logic gw, aw, go, gon, ao, aon, gp, adb, acm, sv;
    logic [6:0] addr;
    logic [3:0] cpm;
    logic [2:0] pick;
    int failures = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    hssp_board_model u_board (.gang_strap(gs), .auto_strap(as), .gang_out(go),
        .gang_oe_n(gon), .auto_out(ao), .auto_oe_n(aon), .gang_wire(gw), .auto_wire(aw));
    hssp_strap_status u_dut (.CORE_CLK(clk), .SRST(srst), .GANG_PIN_IN(gw),
        .GANG_PIN_OUT(go), .GANG_PIN_OE_N(gon), .AUTO_PIN_IN(aw), .AUTO_PIN_OUT(ao),
        .AUTO_PIN_OE_N(aon), .TWOWIRE_SLAVE_MODE_SELECT_N(sel_n), .SLAVE_ADDR_OTHER(oth),
        .STATUS_PIN_OUTPUT_ENABLE(en), .UPSTREAM_HIGHSPEED_LINK_STATUS(lnk),
        .UPSTREAM_HIGHSPEED_SUSPEND_STATUS(sus), .CHARGING_DOWNSTREAM_PORT_REQUEST(req),
        .SLAVE_ADDR(addr), .GANGED_POWER(gp), .AUTO_CHARGE_DISABLE_BIT(adb),
        .AUTO_CHARGE_MODE(acm), .CHARGING_DOWNSTREAM_PORT_MODE(cpm), .STRAPS_VALID(sv));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [6:0] exp_addr(input logic g, input logic m, input logic [6:0] o);
        exp_addr = o;
        if (!m)
            exp_addr[2] = g;
    endfunction
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    initial
    begin
        #50000;
        failures++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'he649c640));
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clk);
            srst <= 1'h1;
            pick = (i < 8) ? 3'(i) : 3'($urandom);
            // auto charge boards strap individual power
            pick[0] = pick[0] & pick[1];
            {sel_n, as, gs} <= pick;
            oth <= 7'($urandom);
            en <= 1'($urandom);
            tick(4);
            @(posedge clk);
            srst <= 1'h0;
            repeat (8) if (sv !== 1'h1) @(negedge clk);
            check({sv, gon, aon}, 3'h7);
            check(gp, gs);
            check({adb, acm}, {as, ~as});
            // address register picks up the captured strap one cycle later
            tick(0);
            check(addr, exp_addr(gs, sel_n, oth));
            @(posedge clk);
            en <= 1'h1;
            lnk <= ~gs;
            sus <= 1'($urandom);
            req <= 4'($urandom);
            tick(2);
            check({gon, aon, gw, aw}, {2'h0, lnk, sus});
            check({gp, adb}, {gs, as});
            check(cpm, req & {3'h7, as});
            @(posedge clk);
            en <= 1'h0;
            tick(2);
            check({gon, aon}, 2'h3);
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule
`default_nettype wire
